// *** adc_consts.svh ***
// Offsets, field positions and clock counts of the addition datapath
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_RESULT      8'h08
`define REG_COUNT       8'h0c
`define CTRL_NARROW_BIT 0
`define CTRL_RESET      1'h0

`define OP_ADD_RM_R8    8'h00
`define OP_ADD_R16_RM   8'h03
`define OP_ADD_ACC8     8'h04
`define OP_ADD_ACC16    8'h05
`define OP_ADC_RM_R8    8'h10
`define OP_ADC_R16_RM   8'h13
`define OP_ADC_ACC8     8'h14
`define OP_ADC_ACC16    8'h15
`define OP_GRP_IMMEDIATE_BYTE     8'h80
`define OP_GRP_IMMEDIATE_WORD    8'h81
`define OP_GRP_SIMM8    8'h83
`define MODRM_ADD       3'h0
`define MODRM_ADC       3'h2

`define CLK_ACC_BYTE    5'h03
`define CLK_ACC_WORD    5'h04
`define CLK_IMM_REG     5'h04
`define CLK_IMM_MEM     5'h10
`define CLK_IMM_MEM_N   5'h14
`define CLK_RR_REG      5'h03
`define CLK_RR_MEM      5'h0a
`define CLK_RR_MEM_N    5'h0e

`define SEXT_ONES       8'hff
`endif

// *** adc_pkg.sv ***
// Types shared by the addition datapath
package adc_pkg;
    typedef enum logic [3:0] {
        FORM_ACC_IMM = 4'b0001,
        FORM_RM_IMM  = 4'b0010,
        FORM_RM_DEST = 4'b0100,
        FORM_REG_DST = 4'b1000
    } form_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } state_t;

    typedef enum logic [1:0] {
        DEST_ACCUM = 2'h0,
        DEST_REG   = 2'h1,
        DEST_RM    = 2'h2
    } dest_t;

    typedef struct packed {
        logic  valid;
        logic  use_carry;
        logic  word;
        logic  sext;
        form_t form;
    } decode_t;
endpackage : adc_pkg

// *** add_flag_unit.sv ***
// Byte or word adder with carry-in and arithmetic flag generation
`timescale 1ns/100ps
`default_nettype none
module add_flag_unit (
    input  wire logic [15:0] a,
    input  wire logic [15:0] b,
    input  wire logic        cin,
    input  wire logic        word,
    output logic      [15:0] sum,
    output logic             cf,
    output logic             af,
    output logic             of,
    output logic             sf,
    output logic             zf,
    output logic             pf
);
    logic [16:0] wide;
    logic [8:0]  narrow;

    assign wide   = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    assign narrow = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
    assign sum    = word ? wide[15:0] : {8'h00, narrow[7:0]};
    // Carry from the top bit of the operand size
    assign cf     = word ? wide[16] : narrow[8];
    // Carry out of the low nibble, kept for decimal adjust
    assign af     = a[4] ^ b[4] ^ wide[4];
    assign sf     = word ? wide[15] : narrow[7];
    assign of     = word ? (a[15] == b[15]) && (wide[15] != a[15])
                         : (a[7] == b[7]) && (narrow[7] != a[7]);
    assign zf     = word ? (wide[15:0] == 16'h0000) : (narrow[7:0] == 8'h00);
    // Parity covers the low byte only, as on the classic core
    assign pf     = ~^narrow[7:0];
endmodule : add_flag_unit
`default_nettype wire

// *** add_with_carry_datapath.sv ***
// Execution unit for the plain and carry addition instructions
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "adc_consts.svh"
module add_with_carry_datapath
    import adc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [2:0]  modrm_reg,
    input  wire logic        rm_is_mem,
    input  wire logic [15:0] accum_word,
    input  wire logic [15:0] reg_operand,
    input  wire logic [15:0] rm_operand,
    input  wire logic [15:0] immediate_word,
    input  wire logic        carry_flag,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    output logic             busy,
    output logic             done,
    output logic             illegal,
    output logic      [15:0] result,
    output dest_t            dest,
    output logic             word_op,
    output logic             carry_flag_new,
    output logic             aux_carry_flag,
    output logic             overflow_flag,
    output logic             sign_flag,
    output logic             zero_flag,
    output logic             parity_flag
);
    ////////////////////////////////////////////////////////////////////////
    function automatic decode_t decode(input logic [7:0] op, input logic [2:0] rg);
        decode_t d;
        d = '{valid: 1'b0, use_carry: 1'b0, word: op[0], sext: 1'b0,
              form: FORM_ACC_IMM};
        if ((op >= `OP_ADD_RM_R8 && op <= `OP_ADD_R16_RM) ||
            (op >= `OP_ADC_RM_R8 && op <= `OP_ADC_R16_RM)) begin
            d.valid     = 1'b1;
            d.use_carry = op[4];
            d.form      = op[1] ? FORM_REG_DST : FORM_RM_DEST;
        end else if (op == `OP_ADD_ACC8 || op == `OP_ADD_ACC16 ||
                     op == `OP_ADC_ACC8 || op == `OP_ADC_ACC16) begin
            d.valid     = 1'b1;
            d.use_carry = op[4];
        end else if ((op == `OP_GRP_IMMEDIATE_BYTE || op == `OP_GRP_IMMEDIATE_WORD ||
                      op == `OP_GRP_SIMM8) &&
                     (rg == `MODRM_ADD || rg == `MODRM_ADC)) begin
            d.valid     = 1'b1;
            d.use_carry = (rg == `MODRM_ADC);
            d.word      = (op != `OP_GRP_IMMEDIATE_BYTE);
            d.sext      = (op == `OP_GRP_SIMM8);
            d.form      = FORM_RM_IMM;
        end
        return d;
    endfunction : decode

    function automatic logic [4:0] clocks(input form_t f, input logic w,
                                          input logic mem, input logic narrow);
        logic [4:0] c;
        c = `CLK_RR_REG;
        case (f)
            FORM_ACC_IMM: c = w ? `CLK_ACC_WORD : `CLK_ACC_BYTE;
            FORM_RM_IMM: begin
                if (!mem)
                    c = `CLK_IMM_REG;
                else if (w && narrow)
                    c = `CLK_IMM_MEM_N;
                else
                    c = `CLK_IMM_MEM;
            end
            FORM_RM_DEST, FORM_REG_DST: begin
                if (!mem)
                    c = `CLK_RR_REG;
                else if (w && narrow)
                    c = `CLK_RR_MEM_N;
                else
                    c = `CLK_RR_MEM;
            end
            default: c = `CLK_RR_REG;
        endcase
        return c;
    endfunction : clocks

    ////////////////////////////////////////////////////////////////////////
    state_t      state;
    decode_t     dec;
    logic        accept;
    logic [4:0]  cnt;
    logic [4:0]  elapsed;
    form_t       run_form;
    logic        run_word;
    logic        run_carry;
    logic        run_mem;
    logic [15:0] run_a;
    logic [15:0] run_b;
    logic        run_cin;
    logic [15:0] next_a;
    logic [15:0] next_b;
    logic [15:0] imm_ext;
    logic [15:0] sum;
    logic        u_cf;
    logic        u_af;
    logic        u_of;
    logic        u_sf;
    logic        u_zf;
    logic        u_pf;
    logic        narrow_bus;
    logic [15:0] done_count;

    assign dec    = decode(opcode, modrm_reg);
    assign busy   = (state == ST_RUN);
    assign accept = ce && start && (state == ST_IDLE) && dec.valid;

    // Byte immediate fills the upper byte from its sign before a word add
    assign imm_ext = dec.sext ? {(immediate_word[7] ? `SEXT_ONES : 8'h00),
                                 immediate_word[7:0]} : immediate_word;

    always_comb begin
        next_a = rm_operand;
        next_b = imm_ext;
        case (dec.form)
            FORM_ACC_IMM: next_a = accum_word;
            FORM_RM_IMM:  next_a = rm_operand;
            FORM_RM_DEST: next_b = reg_operand;
            FORM_REG_DST: begin
                next_a = reg_operand;
                next_b = rm_operand;
            end
            default: next_a = rm_operand;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt   <= 5'h00;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state <= ST_RUN;
                        cnt   <= clocks(dec.form, dec.word, rm_is_mem, narrow_bus);
                    end
                end
                ST_RUN: begin
                    cnt <= cnt - 5'h01;
                    if (cnt == 5'h01)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_form  <= FORM_ACC_IMM;
            run_word  <= 1'b0;
            run_carry <= 1'b0;
            run_mem   <= 1'b0;
            run_a     <= 16'h0000;
            run_b     <= 16'h0000;
            run_cin   <= 1'b0;
        end else if (accept) begin
            run_form  <= dec.form;
            run_word  <= dec.word;
            run_carry <= dec.use_carry;
            run_mem   <= rm_is_mem;
            run_a     <= next_a;
            run_b     <= next_b;
            // Plain forms never see the incoming carry
            run_cin   <= dec.use_carry & carry_flag;
        end
    end

    add_flag_unit u_add (
        .a    (run_a),
        .b    (run_b),
        .cin  (run_cin),
        .word (run_word),
        .sum  (sum),
        .cf   (u_cf),
        .af   (u_af),
        .of   (u_of),
        .sf   (u_sf),
        .zf   (u_zf),
        .pf   (u_pf)
    );

    // Result, flags and destination change only on completion, so the decoder sees a clean handoff
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done           <= 1'b0;
            illegal        <= 1'b0;
            result         <= 16'h0000;
            dest           <= DEST_ACCUM;
            word_op        <= 1'b0;
            carry_flag_new <= 1'b0;
            aux_carry_flag <= 1'b0;
            overflow_flag  <= 1'b0;
            sign_flag      <= 1'b0;
            zero_flag      <= 1'b0;
            parity_flag    <= 1'b0;
        end else if (ce) begin
            done    <= (state == ST_RUN) && (cnt == 5'h01);
            illegal <= start && (state == ST_IDLE) && !dec.valid;
            if ((state == ST_RUN) && (cnt == 5'h01)) begin
                result         <= sum;
                word_op        <= run_word;
                carry_flag_new <= u_cf;
                aux_carry_flag <= u_af;
                overflow_flag  <= u_of;
                sign_flag      <= u_sf;
                zero_flag      <= u_zf;
                parity_flag    <= u_pf;
                case (run_form)
                    FORM_ACC_IMM: dest <= DEST_ACCUM;
                    FORM_REG_DST: dest <= DEST_REG;
                    default:      dest <= DEST_RM;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            narrow_bus <= `CTRL_RESET;
        else if (ce && wr_stb && addr == `REG_CTRL)
            narrow_bus <= wdata[`CTRL_NARROW_BIT];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            done_count <= 16'h0000;
        else if (ce && wr_stb && addr == `REG_COUNT)
            done_count <= 16'h0000;
        else if (ce && done)
            done_count <= done_count + 16'h0001;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            rdata <= 32'h0000_0000;
            if (rd_stb) begin
                case (addr)
                    `REG_CTRL:   rdata <= {31'h0000_0000, narrow_bus};
                    `REG_STATUS: rdata <= {24'h00_0000, busy, word_op, parity_flag,
                                           zero_flag, sign_flag, overflow_flag,
                                           aux_carry_flag, carry_flag_new};
                    `REG_RESULT: rdata <= {16'h0000, result};
                    `REG_COUNT:  rdata <= {16'h0000, done_count};
                    default:     rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edges spent since acceptance, read only by the checks below
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            elapsed <= 5'h00;
        else if (accept)
            elapsed <= 5'h00;
        else if (ce && state == ST_RUN)
            elapsed <= elapsed + 5'h01;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_acc_byte_clocks: assert property (
        $rose(done) && run_form == FORM_ACC_IMM && !run_word && run_carry
        |-> elapsed == 5'd3) else $error("accumulator byte carry add not 3 clocks");
    a_acc_word_clocks: assert property (
        $rose(done) && run_form == FORM_ACC_IMM && run_word
        |-> elapsed == 5'd4) else $error("accumulator word add not 4 clocks");
    a_imm_byte_clocks: assert property (
        $rose(done) && run_form == FORM_RM_IMM && !run_word
        |-> elapsed == (run_mem ? 5'd16 : 5'd4)) else $error("byte immediate timing");
    a_imm_word_clocks: assert property (
        $rose(done) && run_form == FORM_RM_IMM && run_word
        |-> elapsed == (!run_mem ? 5'd4 : (narrow_bus ? 5'd20 : 5'd16)))
        else $error("word immediate timing");
    a_sext_fill: assert property (
        accept && opcode == `OP_GRP_SIMM8
        |=> run_b[15:8] == {8{$past(immediate_word[7])}}) else $error("sign fill wrong");
    a_sext_timing: assert property (
        accept && opcode == `OP_GRP_SIMM8 && !rm_is_mem |=> ##4 done)
        else $error("sign-extended form not 4 clocks");
    a_rr_clocks: assert property (
        $rose(done) && run_form == FORM_RM_DEST
        |-> elapsed == (!run_mem ? 5'd3 : ((run_word && narrow_bus) ? 5'd14 : 5'd10)))
        else $error("register form timing");
    a_reg_dest_sel: assert property (
        accept && dec.form == FORM_REG_DST && !rm_is_mem && !narrow_bus
        |-> ##4 (done && dest == DEST_REG)) else $error("register destination");
    a_plain_acc_clocks: assert property (
        $rose(done) && run_form == FORM_ACC_IMM && !run_carry && !run_word
        |-> elapsed == 5'd3) else $error("plain accumulator byte timing");
    a_grp_plain_nocarry: assert property (
        accept && opcode == `OP_GRP_IMMEDIATE_WORD && modrm_reg == `MODRM_ADD
        |=> !run_carry && !run_cin) else $error("plain group add used carry");
    a_plain_illegal: assert property (
        ce && start && !busy && opcode == 8'h06 |=> illegal && !busy)
        else $error("unknown opcode accepted");
    a_carry_sum: assert property (
        $rose(done) && run_word
        |-> {carry_flag_new, result} == {1'b0, run_a} + {1'b0, run_b} + {16'h0000, run_cin})
        else $error("carry sum wrong");
    a_plain_sum: assert property (
        accept && !dec.use_carry && carry_flag |=> !run_cin)
        else $error("plain add took carry in");
    a_aux_nibble: assert property (
        $rose(done) |-> aux_carry_flag ==
            (({1'b0, run_a[3:0]} + {1'b0, run_b[3:0]} + {4'h0, run_cin}) > 5'h0f))
        else $error("aux carry wrong");
    a_zero_sign: assert property (
        $rose(done) |-> zero_flag == (result == 16'h0000) &&
                        sign_flag == (run_word ? result[15] : result[7]))
        else $error("zero or sign flag wrong");

    c_carry_word_mem: cover property (accept && dec.use_carry && dec.word && rm_is_mem);
    c_narrow_imm: cover property ($rose(done) && narrow_bus && run_mem && run_word);
    c_sext_neg: cover property (accept && opcode == `OP_GRP_SIMM8 && immediate_word[7]);
    c_overflow: cover property ($rose(done) && overflow_flag);
endmodule : add_with_carry_datapath
`default_nettype wire

// *** add_with_carry_datapath_test.sv ***
// Self-checking bench for the addition datapath
`timescale 1ns/100ps
`default_nettype none
module add_with_carry_datapath_test;
    import adc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic start, rm_is_mem, carry_flag, busy, done, illegal, word_op;
    logic [7:0] opcode;
    logic [2:0] modrm_reg;
    logic [15:0] accum_word, reg_operand, rm_operand, immediate_word, result;
    logic [31:0] rdata;
    dest_t dest;
    logic carry_flag_new, aux_carry_flag, overflow_flag, sign_flag, zero_flag, parity_flag;
    int fails = 0;
    int num_checks = 0;
    int runs = 0;

    always #2.5 core_clk = ~core_clk;

    add_with_carry_datapath dut_u (.core_clk, .rst_n, .ce, .start, .opcode, .modrm_reg,
        .rm_is_mem, .accum_word, .reg_operand, .rm_operand, .immediate_word, .carry_flag,
        .addr, .wdata, .wr_stb, .rd_stb, .rdata, .busy, .done, .illegal, .result, .dest,
        .word_op, .carry_flag_new, .aux_carry_flag, .overflow_flag, .sign_flag,
        .zero_flag, .parity_flag);

    decoder_model dec_u (.core_clk, .done, .illegal, .start, .opcode, .modrm_reg,
        .rm_is_mem, .accum_word, .reg_operand, .rm_operand, .immediate_word, .carry_flag);

    ////////////////////////////////////////////////////////////
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_cnt(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp) begin
            fails++;
            $display("BAD %0t %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : cmp_cnt

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    // Returns {pf, zf, sf, of, af, cf, sum}
    function automatic logic [21:0] ref_add(logic [15:0] a, logic [15:0] b, logic cin,
                                            logic w);
        logic [16:0] s;
        logic [4:0] n;
        logic [15:0] r;
        logic [3:0] f;
        s = w ? a + b + cin : a[7:0] + b[7:0] + cin;
        r = w ? s[15:0] : {8'h00, s[7:0]};
        f[0] = w ? s[16] : s[8];
        f[1] = w ? r[15] : r[7];
        f[2] = w ? (a[15] == b[15]) && (r[15] != a[15]) : (a[7] == b[7]) && (r[7] != a[7]);
        f[3] = (r == 16'h0000);
        n = a[3:0] + b[3:0] + cin;
        return {~^r[7:0], f[3], f[1], f[2], n[4], f[0], r};
    endfunction : ref_add

    task automatic run(input logic [7:0] op, input logic [2:0] rg, input logic mem,
                       input logic nb, input logic [15:0] acc, input logic [15:0] rr,
                       input logic [15:0] rm, input logic [15:0] imm, input logic cin);
        int n, cyc;
        logic ill, w, grp, c;
        logic [15:0] a, b;
        logic [1:0] d;
        grp = (op[7:4] == 4'h8);
        w = grp ? (op != 8'h80) : op[0];
        c = grp ? (rg == 3'h2) : op[4];
        a = grp ? rm : op[2] ? acc : rm;
        b = (op == 8'h83) ? {{8{imm[7]}}, imm[7:0]} : (grp || op[2]) ? imm : rr;
        n = grp ? (!mem ? 4 : (w && nb) ? 20 : 16) : op[2] ? (w ? 4 : 3)
            : (!mem ? 3 : (w && nb) ? 14 : 10);
        d = grp ? 2'h2 : op[2] ? 2'h0 : op[1] ? 2'h1 : 2'h2;
        dec_u.issue(op, rg, mem, acc, rr, rm, imm, cin, cyc, ill);
        if (ill !== 1'b1) begin
            runs++;
        end
        // Model counts the taking edge as well
        cmp_cnt(cyc - 1, n, "clock count");
        cmp_val({10'h0, parity_flag, zero_flag, sign_flag, overflow_flag, aux_carry_flag,
                 carry_flag_new, result}, {10'h0, ref_add(a, b, c & cin, w)}, "sum");
        cmp_val({29'h0, dest, word_op}, {29'h0, d, w}, "destination");
        cmp_val({31'h0, busy}, 32'h0000_0000, "busy at done");
    endtask : run

    ////////////////////////////////////////////////////////////
    task automatic t_forms();
        logic [7:0] ops [15] = '{8'h04, 8'h05, 8'h14, 8'h15, 8'h00, 8'h01, 8'h02, 8'h03,
                                 8'h10, 8'h11, 8'h12, 8'h13, 8'h80, 8'h81, 8'h83};
        for (int i = 0; i < 15; i++) begin
            for (int k = 0; k < 8; k++) begin
                reg_wr(8'h00, {31'h0, k[1]});
                run(ops[i], k[2] ? 3'h2 : 3'h0, k[0], k[1], 16'h8ff9 ^ {12'h0, i[3:0]},
                    16'h7f08, 16'hf0f7, 16'h3c85, k[0] ^ k[1]);
            end
        end
    endtask : t_forms

    task automatic t_edges();
        run(8'h04, 3'h0, 1'b0, 1'b0, 16'h1280, 16'h0, 16'h0, 16'h0080, 1'b1);
        run(8'h83, 3'h0, 1'b1, 1'b1, 16'h0, 16'h0, 16'h0081, 16'hff7f, 1'b1);
        run(8'h83, 3'h2, 1'b0, 1'b1, 16'h0, 16'h0, 16'h0001, 16'h00ff, 1'b1);
        run(8'h15, 3'h0, 1'b0, 1'b1, 16'hffff, 16'h0, 16'h0, 16'h0000, 1'b1);
    endtask : t_edges

    task automatic t_illegal();
        logic [7:0] ops [3] = '{8'h06, 8'h80, 8'h83};
        logic [2:0] rgs [3] = '{3'h0, 3'h1, 3'h7};
        int cyc;
        logic ill;
        for (int i = 0; i < 3; i++) begin
            dec_u.issue(ops[i], rgs[i], 1'b0, 16'h1, 16'h2, 16'h3, 16'h4, 1'b0, cyc, ill);
            cmp_val({31'h0, ill}, 32'h0000_0001, "refused opcode");
            cmp_cnt(cyc, 1, "refusal delay");
            cmp_val({31'h0, busy}, 32'h0000_0000, "busy after refusal");
        end
    endtask : t_illegal

    task automatic t_ce_stretch();
        int cyc;
        logic ill;
        fork
            dec_u.issue(8'h14, 3'h0, 1'b0, 16'h0001, 16'h0, 16'h0, 16'h00fe, 1'b1, cyc, ill);
            begin
                repeat (2) @(posedge core_clk);
                ce <= 1'b0;
                repeat (2) @(posedge core_clk);
                ce <= 1'b1;
            end
        join
        runs++;
        cmp_cnt(cyc - 1, 5, "stretched count");
        cmp_val({15'h0, carry_flag_new, result}, {15'h0, 1'b1, 16'h0000}, "carry sum");
    endtask : t_ce_stretch

    task automatic t_regs();
        logic [31:0] d;
        reg_rd(8'h00, d);
        cmp_val(d, 32'h0000_0001, "narrow bit");
        run(8'h15, 3'h0, 1'b0, 1'b1, 16'hffff, 16'h0, 16'h0, 16'h0000, 1'b1);
        reg_rd(8'h04, d);
        cmp_val(d, 32'h0000_0073, "status");
        reg_rd(8'h08, d);
        cmp_val(d, 32'h0000_0000, "result reg");
        reg_rd(8'h0c, d);
        cmp_val(d, {16'h0, runs[15:0]}, "count reg");
        reg_wr(8'h0c, 32'h0000_0005);
        reg_wr(8'h10, 32'hffff_ffff);
        reg_rd(8'h0c, d);
        cmp_val(d, 32'h0000_0000, "count cleared");
        reg_rd(8'h10, d);
        cmp_val(d, 32'h0000_0000, "unmapped");
        reg_wr(8'h00, 32'h0000_0000);
        reg_rd(8'h00, d);
        cmp_val(d, 32'h0000_0000, "narrow cleared");
    endtask : t_regs

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        reg_rd(8'h00, d);
        cmp_val(d, 32'h0000_0000, "control at reset");
        reg_rd(8'h0c, d);
        cmp_val(d, 32'h0000_0000, "count at reset");
        t_forms();
        t_edges();
        t_illegal();
        t_ce_stretch();
        t_regs();
        complete_run();
    end

    initial begin
        #400_000;
        fails++;
        complete_run();
    end
endmodule : add_with_carry_datapath_test
`default_nettype wire

// *** decoder_model.sv ***
// Decoder and operand fetch model that issues one instruction at a time
`timescale 1ns/100ps
`default_nettype none
module decoder_model (
    input  wire logic        core_clk,
    input  wire logic        done,
    input  wire logic        illegal,
    output var  logic        start,
    output var  logic [7:0]  opcode,
    output var  logic [2:0]  modrm_reg,
    output var  logic        rm_is_mem,
    output var  logic [15:0] accum_word,
    output var  logic [15:0] reg_operand,
    output var  logic [15:0] rm_operand,
    output var  logic [15:0] immediate_word,
    output var  logic        carry_flag
);
    initial begin
        start = 1'b0;
        {opcode, modrm_reg, rm_is_mem, carry_flag} = '0;
        {accum_word, reg_operand, rm_operand, immediate_word} = '0;
    end

    ////////////////////////////////////////////////////////////
    task automatic issue(input logic [7:0] op, input logic [2:0] rg, input logic mem,
                         input logic [15:0] acc, input logic [15:0] rr,
                         input logic [15:0] rm, input logic [15:0] imm, input logic cin,
                         output int cyc, output logic ill);
        @(posedge core_clk);
        start <= 1'b1;
        opcode <= op;
        modrm_reg <= rg;
        rm_is_mem <= mem;
        {accum_word, reg_operand, rm_operand, immediate_word} <= {acc, rr, rm, imm};
        carry_flag <= cin;
        cyc = 0;
        do begin
            @(posedge core_clk);
            if (cyc == 0) begin
                // Operands only promised at the taking edge, so scramble them
                start <= 1'b0;
                {accum_word, reg_operand, rm_operand, immediate_word} <= ~{acc, rr, rm, imm};
                carry_flag <= ~cin;
            end
            cyc++;
            #1;
        end while (done !== 1'b1 && illegal !== 1'b1 && cyc < 40);
        ill = illegal;
    endtask : issue
endmodule : decoder_model
`default_nettype wire
